/* src/bls_defines.svh */
// offsets, field positions, reset values and cycle counts of the exec block
`ifndef BLS_DEFINES_SVH
`define BLS_DEFINES_SVH

// major opcode in word bits 15:12
`define BLS_OP_HI        15
`define BLS_OP_LO        12
`define BLS_OP_BRANCH    4'h1
`define BLS_OP_COPY      4'h2
`define BLS_OP_DIRECT    4'h4
`define BLS_OP_PTR       4'h8
`define BLS_OP_DISP      4'h9
`define BLS_OP_IMM       4'he

// branch fields
`define BLS_BR_POL       11
`define BLS_BR_SIGNED    10
`define BLS_BR_SEL_HI    9
`define BLS_BR_SEL_LO    7
`define BLS_BR_K_HI      6

// pointer and displacement fields
`define BLS_PTR_STORE    11
`define BLS_PTR_SEL_HI   10
`define BLS_PTR_SEL_LO   9
`define BLS_PTR_MODE_HI  8
`define BLS_PTR_MODE_LO  7
`define BLS_DISP_ZSEL    11
`define BLS_DISP_Q_HI    10
`define BLS_DISP_Q_LO    5

// flag register bit positions
`define BLS_FLAG_C       0
`define BLS_FLAG_Z       1
`define BLS_FLAG_N       2
`define BLS_FLAG_V       3
`define BLS_FLAG_S       4
`define BLS_FLAG_H       5
`define BLS_FLAG_T       6
`define BLS_FLAG_I       7

// register file layout
`define BLS_IMM_BASE     5'h10
`define BLS_PTR_X_LO     5'h1a
`define BLS_PTR_Y_LO     5'h1c
`define BLS_PTR_Z_LO     5'h1e
`define BLS_REG_RESET    8'h00
`define BLS_PC_RESET     16'h0000

// cycle counts
`define BLS_MEM_CYCLES   2
`define BLS_TAKEN_CYCLES 2

`endif

/* src/bls_pkg.sv */
// types shared by the branch and load/store exec block
`default_nettype none

package bls_pkg;

    typedef enum logic [3:0] {
        BLS_ST_IDLE = 4'b0001,
        BLS_ST_BR   = 4'b0010,
        BLS_ST_LD   = 4'b0100,
        BLS_ST_ST   = 4'b1000
    } bls_state_t;

    typedef enum logic [1:0] {
        BLS_PM_PLAIN = 2'h0,
        BLS_PM_POST  = 2'h1,
        BLS_PM_PRE   = 2'h2
    } bls_pmode_t;

endpackage

`default_nettype wire

/* src/bls_regfile.sv */
// general-purpose register file with byte and pointer-pair ports
`default_nettype none
`include "bls_defines.svh"

module bls_regfile #(
    parameter int NREG = 32
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [4:0]  rd_addr,
    output logic      [7:0]  rd_data,
    input  wire logic [4:0]  peek_addr,
    output logic      [7:0]  peek_data,
    input  wire logic [4:0]  pair_raddr,
    output logic      [15:0] pair_rdata,
    input  wire logic        byte_we,
    input  wire logic [4:0]  byte_addr,
    input  wire logic [7:0]  byte_data,
    input  wire logic        pair_we,
    input  wire logic [4:0]  pair_waddr,
    input  wire logic [15:0] pair_wdata
);

    // five-bit register numbers reach exactly 32 entries
    if (NREG != 32)
    begin : g_check
        $error("bls_regfile: NREG must be 32");
    end

    logic [7:0] regs_q [NREG];

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_q[i] <= `BLS_REG_RESET;
            end
        end
        else
        begin
            if (byte_we)
            begin
                regs_q[byte_addr] <= byte_data;
            end
            // carry across the full 16 bits comes from the caller's sum
            if (pair_we)
            begin
                regs_q[{pair_waddr[4:1], 1'b0}] <= pair_wdata[7:0];
                regs_q[{pair_waddr[4:1], 1'b1}] <= pair_wdata[15:8];
            end
        end
    end

    assign rd_data    = regs_q[rd_addr];
    assign peek_data  = regs_q[peek_addr];
    assign pair_rdata = {regs_q[{pair_raddr[4:1], 1'b1}], regs_q[{pair_raddr[4:1], 1'b0}]};

endmodule

`default_nettype wire

/* src/bls_exec.sv */
// exec unit for flag branches, register moves and pointer loads/stores
////////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1: generic branch when selected flag clear
// RQ2: equal branch when zero flag set
// RQ3: not-equal branch when zero flag clear
// RQ4: carry-set and lower alias branch alike
// RQ5: carry-clear and same-or-higher branch alike
// RQ6: minus/plus branch on negative flag
// RQ7: signed ge branches when N xor V zero
// RQ8: signed less branches when N xor V one
// RQ9: half-carry pair branches on half-carry flag
// RQ10: transfer-bit pair branches on T flag
// RQ11: overflow pair branches on overflow flag
// RQ12: interrupt pair branches on global enable
// RQ13: copy and immediate load, one cycle
// RQ14: pointer load, optional post-increment, two cycles
// RQ15: pre-decrement pointer, then load, two cycles
// RQ16: Y/Z plus displacement load, pointer kept
// RQ17: direct load from embedded address
// RQ18: pointer store, optional post-increment, two cycles
// RQ19: pre-decrement pointer, then store
// RQ20: branch one cycle untaken, two taken
// RQ21: pointers are 16-bit register pairs
// RQ22: displacement is unsigned six-bit field
////////////////////////////////////////////////////////////////////////////////
`default_nettype none
`include "bls_defines.svh"

module bls_exec #(
    parameter int PC_W = 16
) (
    input  wire logic            clock,
    input  wire logic            reset,
    input  wire logic            issue_valid,
    output logic                 issue_ready,
    input  wire logic [15:0]     issue_word,
    input  wire logic [15:0]     issue_ext,
    input  wire logic [7:0]      flag_register,
    output logic      [PC_W-1:0] pc,
    output logic                 fetch_flush,
    output logic      [15:0]     sram_addr,
    output logic      [7:0]      sram_wdata,
    output logic                 sram_read,
    output logic                 sram_write,
    input  wire logic [7:0]      sram_rdata,
    output logic                 illegal_op,
    input  wire logic [4:0]      peek_addr,
    output logic      [7:0]      peek_data
);

    if (PC_W < 8 || PC_W > 16)
    begin : g_check
        $error("bls_exec: PC_W must lie in 8..16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic branch_taken(input logic [7:0] f, input logic [15:0] w);
        logic bit_v;
        bit_v = w[`BLS_BR_SIGNED] ? (f[`BLS_FLAG_N] ^ f[`BLS_FLAG_V]) // RQ7 RQ8
                                  : f[w[`BLS_BR_SEL_HI:`BLS_BR_SEL_LO]]; // RQ4 RQ6 RQ9 RQ10
        return bit_v == w[`BLS_BR_POL]; // RQ3 RQ5 RQ11 RQ12
    endfunction

    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        logic [4:0] b;
        case (sel)
            2'h0:    b = `BLS_PTR_X_LO;
            2'h1:    b = `BLS_PTR_Y_LO;
            default: b = `BLS_PTR_Z_LO;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    bls_pkg::bls_state_t state_q;
    bls_pkg::bls_state_t state_d;
    logic [PC_W-1:0]     pc_q;
    logic [PC_W-1:0]     pc_d;
    logic                flush_q;
    logic                flush_d;
    logic [15:0]         mem_addr_q;
    logic [15:0]         mem_addr_d;
    logic [7:0]          mem_wdata_q;
    logic [7:0]          mem_wdata_d;
    logic                mem_rd_q;
    logic                mem_rd_d;
    logic                mem_wr_q;
    logic                mem_wr_d;
    logic [4:0]          dest_q;
    logic [4:0]          dest_d;
    logic                illegal_q;
    logic                illegal_d;

    logic [3:0]          op;
    logic                issue_fire;
    logic [PC_W-1:0]     br_target;
    logic [1:0]          pmode;
    logic [5:0]          disp_q6;

    logic [4:0]          rd_addr;
    logic [7:0]          rd_data;
    logic [4:0]          pair_raddr;
    logic [15:0]         pair_rdata;
    logic                byte_we;
    logic [4:0]          byte_addr;
    logic [7:0]          byte_data;
    logic                pair_we;
    logic [15:0]         pair_wdata;

    assign op          = issue_word[`BLS_OP_HI:`BLS_OP_LO];
    assign issue_ready = (state_q == bls_pkg::BLS_ST_IDLE);
    assign issue_fire  = issue_valid && issue_ready;
    assign pmode       = issue_word[`BLS_PTR_MODE_HI:`BLS_PTR_MODE_LO];
    assign disp_q6     = issue_word[`BLS_DISP_Q_HI:`BLS_DISP_Q_LO];
    // seven-bit offset, sign-extended, plus one
    assign br_target   = pc_q + PC_W'({{9{issue_word[`BLS_BR_K_HI]}},
                                       issue_word[`BLS_BR_K_HI:0]}) + PC_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // decode and sequencing

    always_comb
    begin
        state_d     = state_q;
        pc_d        = pc_q;
        flush_d     = 1'b0;
        mem_addr_d  = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        mem_rd_d    = 1'b0;
        mem_wr_d    = 1'b0;
        dest_d      = dest_q;
        illegal_d   = 1'b0;
        rd_addr     = issue_word[4:0];
        pair_raddr  = ptr_base(issue_word[`BLS_PTR_SEL_HI:`BLS_PTR_SEL_LO]);
        byte_we     = 1'b0;
        byte_addr   = issue_word[9:5];
        byte_data   = rd_data;
        pair_we     = 1'b0;
        pair_wdata  = pair_rdata;
        case (state_q)
            bls_pkg::BLS_ST_IDLE:
            begin
                if (issue_valid)
                begin
                    pc_d = pc_q + PC_W'(1);
                    case (op)
                        `BLS_OP_BRANCH:
                        begin
                            // flags are only read here, never written
                            if (branch_taken(flag_register, issue_word)) // RQ1
                            begin
                                pc_d    = br_target; // RQ2
                                flush_d = 1'b1;
                                state_d = bls_pkg::BLS_ST_BR; // RQ20
                            end
                        end
                        `BLS_OP_COPY:
                        begin
                            byte_we   = 1'b1; // RQ13
                            byte_addr = issue_word[9:5];
                            byte_data = rd_data;
                        end
                        `BLS_OP_IMM:
                        begin
                            // immediate reaches only the upper sixteen registers
                            byte_we   = 1'b1; // RQ13
                            byte_addr = `BLS_IMM_BASE | {1'b0, issue_word[3:0]};
                            byte_data = issue_word[11:4];
                        end
                        `BLS_OP_DIRECT:
                        begin
                            // second word holds the address
                            pc_d       = pc_q + PC_W'(2);
                            mem_addr_d = issue_ext; // RQ17
                            mem_rd_d   = 1'b1;
                            dest_d     = issue_word[4:0];
                            state_d    = bls_pkg::BLS_ST_LD;
                        end
                        `BLS_OP_PTR:
                        begin
                            if (pmode == 2'h3 ||
                                issue_word[`BLS_PTR_SEL_HI:`BLS_PTR_SEL_LO] == 2'h3)
                            begin
                                illegal_d = 1'b1;
                            end
                            else
                            begin
                                mem_addr_d = pair_rdata; // RQ14
                                if (pmode == bls_pkg::BLS_PM_PRE)
                                begin
                                    mem_addr_d = pair_rdata - 16'h0001; // RQ15
                                    pair_wdata = pair_rdata - 16'h0001; // RQ21
                                    pair_we    = 1'b1; // RQ19
                                end
                                else if (pmode == bls_pkg::BLS_PM_POST)
                                begin
                                    pair_wdata = pair_rdata + 16'h0001; // RQ21
                                    pair_we    = 1'b1; // RQ18
                                end
                                if (issue_word[`BLS_PTR_STORE])
                                begin
                                    mem_wr_d    = 1'b1; // RQ18
                                    mem_wdata_d = rd_data;
                                    state_d     = bls_pkg::BLS_ST_ST;
                                end
                                else
                                begin
                                    mem_rd_d = 1'b1; // RQ14
                                    dest_d   = issue_word[4:0];
                                    state_d  = bls_pkg::BLS_ST_LD;
                                end
                            end
                        end
                        `BLS_OP_DISP:
                        begin
                            pair_raddr = issue_word[`BLS_DISP_ZSEL] ? `BLS_PTR_Z_LO
                                                                    : `BLS_PTR_Y_LO;
                            mem_addr_d = pair_rdata + {10'h000, disp_q6}; // RQ22
                            mem_rd_d   = 1'b1; // RQ16
                            dest_d     = issue_word[4:0];
                            state_d    = bls_pkg::BLS_ST_LD;
                        end
                        default:
                        begin
                            illegal_d = 1'b1;
                        end
                    endcase
                end
            end
            bls_pkg::BLS_ST_BR:
            begin
                // target fetch slot after the redirect
                state_d = bls_pkg::BLS_ST_IDLE; // RQ20
            end
            bls_pkg::BLS_ST_LD:
            begin
                byte_we   = 1'b1; // RQ14
                byte_addr = dest_q;
                byte_data = sram_rdata;
                state_d   = bls_pkg::BLS_ST_IDLE;
            end
            bls_pkg::BLS_ST_ST:
            begin
                state_d = bls_pkg::BLS_ST_IDLE; // RQ18
            end
            default:
            begin
                state_d = bls_pkg::BLS_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= bls_pkg::BLS_ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pc_q    <= PC_W'(`BLS_PC_RESET);
            flush_q <= 1'b0;
        end
        else
        begin
            pc_q    <= pc_d;
            flush_q <= flush_d;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            mem_addr_q  <= 16'h0000;
            mem_wdata_q <= 8'h00;
            mem_rd_q    <= 1'b0;
            mem_wr_q    <= 1'b0;
            dest_q      <= 5'h00;
        end
        else
        begin
            mem_addr_q  <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            mem_rd_q    <= mem_rd_d;
            mem_wr_q    <= mem_wr_d;
            dest_q      <= dest_d;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            illegal_q <= 1'b0;
        end
        else
        begin
            illegal_q <= illegal_d;
        end
    end

    assign pc          = pc_q;
    assign fetch_flush = flush_q;
    assign sram_addr   = mem_addr_q;
    assign sram_wdata  = mem_wdata_q;
    assign sram_read   = mem_rd_q;
    assign sram_write  = mem_wr_q;
    assign illegal_op  = illegal_q;

    bls_regfile #(
        .NREG (32)
    ) u_regs (
        .clock      (clock),
        .reset      (reset),
        .rd_addr    (rd_addr),
        .rd_data    (rd_data),
        .peek_addr  (peek_addr),
        .peek_data  (peek_data),
        .pair_raddr (pair_raddr),
        .pair_rdata (pair_rdata),
        .byte_we    (byte_we),
        .byte_addr  (byte_addr),
        .byte_data  (byte_data),
        .pair_we    (pair_we),
        .pair_waddr (pair_raddr),
        .pair_wdata (pair_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    logic is_branch;
    logic is_ptr_ld;
    logic is_ptr_st;
    assign is_branch = issue_fire && op == `BLS_OP_BRANCH;
    assign is_ptr_ld = issue_fire && op == `BLS_OP_PTR && !issue_word[`BLS_PTR_STORE]
                       && !illegal_d;
    assign is_ptr_st = issue_fire && op == `BLS_OP_PTR && issue_word[`BLS_PTR_STORE]
                       && !illegal_d;

    sequence s_busy_one;
        !issue_ready ##1 issue_ready;
    endsequence

    sequence s_mem_read;
        sram_read ##1 !sram_read;
    endsequence

    a_generic_clear_taken: // RQ1
    assert property (is_branch && !issue_word[`BLS_BR_SIGNED] && !issue_word[`BLS_BR_POL]
                     && !flag_register[issue_word[`BLS_BR_SEL_HI:`BLS_BR_SEL_LO]]
                     |=> pc == $past(br_target) && fetch_flush)
        else $error("clear-flag branch did not redirect");

    a_not_equal_held: // RQ3
    assert property (is_branch && !issue_word[`BLS_BR_SIGNED] && !issue_word[`BLS_BR_POL]
                     && issue_word[`BLS_BR_SEL_HI:`BLS_BR_SEL_LO] == 3'(`BLS_FLAG_Z)
                     && flag_register[`BLS_FLAG_Z]
                     |=> pc == $past(pc) + PC_W'(1) && issue_ready)
        else $error("not-equal branch taken with zero flag set");

    a_signed_ge_taken: // RQ7
    assert property (is_branch && issue_word[`BLS_BR_SIGNED] && !issue_word[`BLS_BR_POL]
                     && (flag_register[`BLS_FLAG_N] == flag_register[`BLS_FLAG_V])
                     |=> pc == $past(br_target))
        else $error("signed ge branch missed");

    a_taken_two_cycles: // RQ20
    assert property (is_branch && branch_taken(flag_register, issue_word)
                     |=> fetch_flush ##0 s_busy_one)
        else $error("taken branch not two cycles");

    a_copy_one_cycle: // RQ13
    assert property (issue_fire && op == `BLS_OP_COPY
                     |=> issue_ready && !sram_read && !sram_write)
        else $error("register copy not single cycle");

    a_load_two_cycles: // RQ14
    assert property (is_ptr_ld |=> s_mem_read and s_busy_one)
        else $error("pointer load not two cycles");

    a_predec_address: // RQ15
    assert property (is_ptr_ld && pmode == bls_pkg::BLS_PM_PRE
                     |=> sram_addr == $past(pair_rdata) - 16'h0001)
        else $error("pre-decrement load used wrong address");

    a_disp_address: // RQ16
    assert property (issue_fire && op == `BLS_OP_DISP
                     |=> sram_read && sram_addr == $past(pair_rdata) + {10'h000, $past(disp_q6)})
        else $error("displacement load used wrong address");

    a_direct_address: // RQ17
    assert property (issue_fire && op == `BLS_OP_DIRECT
                     |=> sram_read && sram_addr == $past(issue_ext)
                         && pc == $past(pc) + PC_W'(2))
        else $error("direct load address wrong");

    a_store_strobe: // RQ18
    assert property (is_ptr_st
                     |=> sram_write && sram_wdata == $past(rd_data) ##1 !sram_write)
        else $error("store strobe wrong");

    a_pointer_wrap: // RQ21
    assert property (issue_fire && op == `BLS_OP_PTR && pmode == bls_pkg::BLS_PM_PRE
                     && pair_rdata == 16'h0000 && !illegal_d
                     |-> pair_we && pair_wdata == 16'hffff)
        else $error("pointer decrement did not wrap over 16 bits");

endmodule

`default_nettype wire

/* verif/bls_sram_model.sv */
// data memory model on the far side of the exec block
`default_nettype none

module bls_sram_model (
    input  wire logic        clock,
    input  wire logic [15:0] sram_addr,
    input  wire logic [7:0]  sram_wdata,
    input  wire logic        sram_read,
    input  wire logic        sram_write,
    output logic      [7:0]  sram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;

    // deselected data lines show the inverse of the last value, never a stale copy
    always_comb sram_rdata = sram_read ? mem[sram_addr] : ~last_q;

    always_ff @(posedge clock)
    begin
        if (sram_write)
            mem[sram_addr] <= sram_wdata;
        if (sram_read)
            last_q <= mem[sram_addr];
    end
endmodule

`default_nettype wire

/* verif/test_branch_and_load_store_exec.sv */
// self-checking bench for the branch and load/store exec block
`default_nettype none

module test_branch_and_load_store_exec;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock = 1'h0;
    logic        reset = 1'h1;
    logic        issue_valid = 1'h0;
    logic [15:0] issue_word = 16'h0000;
    logic [15:0] issue_ext = 16'h0000;
    logic [7:0]  flag_register = 8'h00;
    logic [4:0]  peek_addr = 5'h00;
    logic        issue_ready, fetch_flush, sram_read, sram_write, illegal_op;
    logic [15:0] pc, sram_addr;
    logic [7:0]  sram_wdata, sram_rdata, peek_data;
    logic [15:0] exp_pc = 16'h0000;
    int          errors = 0;
    int          n_tests = 0;

    bls_exec #(.PC_W(16)) i_dut (.clock(clock), .reset(reset), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_word(issue_word), .issue_ext(issue_ext),
        .flag_register(flag_register), .pc(pc), .fetch_flush(fetch_flush),
        .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_read(sram_read),
        .sram_write(sram_write), .sram_rdata(sram_rdata), .illegal_op(illegal_op),
        .peek_addr(peek_addr), .peek_data(peek_data));

    bls_sram_model i_mem (.clock(clock), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
        .sram_read(sram_read), .sram_write(sram_write), .sram_rdata(sram_rdata));

    initial forever #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // offer a word once ready; returns at the falling edge after it was taken
    task automatic issue(input logic [15:0] w, input logic [15:0] x);
        int n;
        n = 0;
        // one idle edge first: valid never falls and rises in one step
        @(negedge clock);
        while (issue_ready !== 1'h1 && n < 8)
        begin
            @(negedge clock);
            n++;
        end
        if (issue_ready !== 1'h1)
        begin
            chk("ready wait", 16'h1, 16'h0);
            wrap_up();
        end
        issue_valid = 1'h1;
        issue_word = w;
        issue_ext = x;
        @(negedge clock);
        issue_valid = 1'h0;
    endtask

    task automatic reg_is(input logic [4:0] r, input logic [7:0] v);
        @(negedge clock);
        peek_addr = r;
        #1;
        chk("register", {8'h00, v}, {8'h00, peek_data});
    endtask

    task automatic immediate_load(input logic [4:0] rd, input logic [7:0] k);
        issue({4'he, k, rd[3:0]}, 16'h0000);
        exp_pc = exp_pc + 16'h1;
        chk("ready", 16'h1, {15'h0, issue_ready});
    endtask

    task automatic br(input logic p, input logic s, input logic [2:0] f,
                      input logic [7:0] fl, input logic tk);
        logic [6:0] k;
        k = tk ? 7'h7d : 7'h05;
        flag_register = fl;
        issue({4'h1, p, s, f, k}, 16'h0000);
        exp_pc = exp_pc + (tk ? {{9{k[6]}}, k} + 16'h1 : 16'h1);
        chk("flush", {15'h0, tk}, {15'h0, fetch_flush});
        chk("ready", {15'h0, ~tk}, {15'h0, issue_ready});
        chk("pc", exp_pc, pc);
    endtask

    task automatic mem(input logic [15:0] w, input logic [15:0] x, input logic [15:0] a,
                       input logic st);
        issue(w, x);
        exp_pc = exp_pc + ((w[15:12] == 4'h4) ? 16'h2 : 16'h1);
        chk("ready", 16'h0, {15'h0, issue_ready});
        chk("address", a, sram_addr);
        chk("strobes", st ? 16'h2 : 16'h1, {14'h0, sram_write, sram_read});
        @(negedge clock);
        chk("pc", exp_pc, pc);
        chk("ready", 16'h1, {15'h0, issue_ready});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_moves;
        immediate_load(5'h10, 8'ha5);
        immediate_load(5'h1f, 8'h3c);
        issue({4'h2, 2'h0, 5'h00, 5'h10}, 16'h0000);
        exp_pc = exp_pc + 16'h1;
        chk("pc", exp_pc, pc);
        reg_is(5'h00, 8'ha5);
        reg_is(5'h1f, 8'h3c);
        $display("done moves");
    endtask

    task automatic t_branch;
        for (int i = 0; i < 8; i++)
            for (int p = 0; p < 2; p++)
                for (int v = 0; v < 2; v++)
                    br(p[0], 1'h0, i[2:0], v[0] ? 8'h01 << i : ~(8'h01 << i), v == p);
        for (int p = 0; p < 2; p++)
            for (int nv = 0; nv < 4; nv++)
                br(p[0], 1'h1, 3'h0, {4'h0, nv[1:0], 2'h0}, (nv[1] ^ nv[0]) == p[0]);
        $display("done branches");
    endtask

    // pointer edges sit at 00ff/0100 so inc and dec carry into the high byte
    task automatic t_mem;
        immediate_load(5'h1a, 8'hff);
        immediate_load(5'h1b, 8'h00);
        immediate_load(5'h11, 8'h5a);
        mem({4'h8, 1'h1, 2'h0, 2'h1, 2'h0, 5'h10}, 16'h0, 16'h00ff, 1'h1);
        chk("memory", 16'h00a5, {8'h00, i_mem.mem[16'h00ff]});
        reg_is(5'h1a, 8'h00);
        reg_is(5'h1b, 8'h01);
        mem({4'h8, 1'h1, 2'h0, 2'h2, 2'h0, 5'h11}, 16'h0, 16'h00ff, 1'h1);
        chk("memory", 16'h005a, {8'h00, i_mem.mem[16'h00ff]});
        immediate_load(5'h1e, 8'h00);
        immediate_load(5'h1f, 8'h01);
        mem({4'h8, 1'h0, 2'h2, 2'h2, 2'h0, 5'h00}, 16'h0, 16'h00ff, 1'h0);
        reg_is(5'h00, 8'h5a);
        reg_is(5'h1f, 8'h00);
        mem({4'h8, 1'h0, 2'h2, 2'h1, 2'h0, 5'h01}, 16'h0, 16'h00ff, 1'h0);
        reg_is(5'h01, 8'h5a);
        reg_is(5'h1f, 8'h01);
        immediate_load(5'h1c, 8'hc0);
        immediate_load(5'h1d, 8'h00);
        mem({4'h8, 1'h1, 2'h1, 2'h0, 2'h0, 5'h10}, 16'h0, 16'h00c0, 1'h1);
        mem({4'h9, 1'h0, 6'h3f, 5'h03}, 16'h0, 16'h00ff, 1'h0);
        reg_is(5'h03, 8'h5a);
        reg_is(5'h1c, 8'hc0);
        mem({4'h4, 7'h00, 5'h04}, 16'h00c0, 16'h00c0, 1'h0);
        reg_is(5'h04, 8'ha5);
        // pre-decrement from 0000 must wrap the whole pair to ffff
        immediate_load(5'h1a, 8'h00);
        mem({4'h8, 1'h1, 2'h0, 2'h2, 2'h0, 5'h10}, 16'h0, 16'hffff, 1'h1);
        chk("memory", 16'h00a5, {8'h00, i_mem.mem[16'hffff]});
        reg_is(5'h1a, 8'hff);
        reg_is(5'h1b, 8'hff);
        $display("done memory");
    endtask

    task automatic t_illegal;
        issue({4'h8, 1'h0, 2'h3, 2'h0, 2'h0, 5'h00}, 16'h0000);
        exp_pc = exp_pc + 16'h1;
        chk("illegal", 16'h1, {15'h0, illegal_op});
        chk("pc", exp_pc, pc);
        $display("done illegal");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        chk("reset pc", 16'h0000, pc);
        reset = 1'h0;
        t_moves();
        t_branch();
        t_mem();
        t_illegal();
        wrap_up();
    end
endmodule

`default_nettype wire
